// ==== sdm_pkg.sv ====
// shared constants and pin bundle for the slope delta modulator core
// assumes one system clock; every documented pin is asynchronous to it
package sdm_pkg;
    // history length of the higher-rate variant; the lower-rate one uses 3
    localparam int HIST_LEN_DEFAULT = 4;
    localparam int HIST_LEN_MAX = 8;
    // alternating one-zero preload, so the coincidence output starts inactive
    localparam logic [7:0] IDLE_PATTERN = 8'haa;
    localparam int SYNC_STAGES = 3;
    localparam logic COINC_INACTIVE = 1'h1;

    typedef struct packed {
        logic bit_clk;
        logic cmp_above;
        logic data_in;
        logic encode_sel;
    } sdm_pins_type;

    localparam sdm_pins_type PINS_RESET = '{
        bit_clk: 1'h0,
        cmp_above: 1'h0,
        data_in: 1'h0,
        encode_sel: 1'h0
    };
endpackage

// ==== sdm_pin_sync.sv ====
// three-stage synchroniser for the pin bundle
// assumes all pins are asynchronous to i_clk; the first stage is read only here
`timescale 1ns/100ps
module sdm_pin_sync (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire sdm_pkg::sdm_pins_type i_pins,
    output sdm_pkg::sdm_pins_type o_stage2,
    output sdm_pkg::sdm_pins_type o_stage3
);
    sdm_pkg::sdm_pins_type stage1;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= sdm_pkg::PINS_RESET;
            o_stage2 <= sdm_pkg::PINS_RESET;
            o_stage3 <= sdm_pkg::PINS_RESET;
        end else begin
            stage1 <= i_pins;
            o_stage2 <= stage1;
            o_stage3 <= o_stage2;
        end
    end
endmodule

// ==== sdm_core.sv ====
// digital core of a continuously variable slope delta modulator codec
// assumes the bit clock, comparator sign, data and mode all arrive as pins
`timescale 1ns/100ps

// Functional notes
// (R1) digital output changes only after a bit clock falling edge, stable otherwise
// (R2) encode: output low when analog input above feedback, else high
// (R3) coincidence output low when history is all ones or all zeros
// (R4) history length is a parameter: 3 or 4 stages, all checked
// (R5) history shifts once per falling edge, new bit enters first stage
// (R6) mode select high loads the analog comparison result
// (R7) mode select low loads the serial data input instead
// (R8) data input is inverted relative to the digital output
// (R9) ramp up when input above feedback, or data high in decode
// (R10) exactly one bit per bit clock cycle
// (R11) far side supplies the received stream on the data input
// (R12) output looped to data input in decode gives a toggling idle pattern
// (R13) the output sign bit also directs the integrator ramp
// (R14) reset preloads history with alternating ones and zeros
module sdm_core #(
    parameter int HIST_LEN = sdm_pkg::HIST_LEN_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bit_clk,
    input wire logic i_cmp_above,
    input wire logic i_data_in,
    input wire logic i_encode_sel,
    output logic o_digital_out,
    output logic o_ramp_up,
    output logic o_coinc_n,
    output logic o_bit_strobe
);
    localparam logic [HIST_LEN-1:0] HIST_IDLE = sdm_pkg::IDLE_PATTERN[HIST_LEN-1:0];
    localparam int PIN_BITS = $bits(sdm_pkg::sdm_pins_type);
    localparam logic [PIN_BITS-1:0] PINS_IDLE = sdm_pkg::PINS_RESET;

    sdm_pkg::sdm_pins_type pins;
    sdm_pkg::sdm_pins_type stage2;
    sdm_pkg::sdm_pins_type stage3;
    sdm_pkg::sdm_pins_type settled;
    logic [PIN_BITS-1:0] stage2_bits;
    logic [PIN_BITS-1:0] stage3_bits;
    logic [PIN_BITS-1:0] settled_bits;
    logic clk_level;
    logic fall;
    logic sel_bit;
    logic [HIST_LEN-1:0] history;
    logic [HIST_LEN-1:0] next_history;

    assign pins = '{
        bit_clk: i_bit_clk,
        cmp_above: i_cmp_above,
        data_in: i_data_in,
        encode_sel: i_encode_sel
    };

    sdm_pin_sync u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pins(pins),
        .o_stage2(stage2),
        .o_stage3(stage3)
    );

    assign stage2_bits = stage2;
    assign stage3_bits = stage3;
    assign settled = settled_bits;

    // a pin level counts only once stages two and three agree, so a level
    // caught in mid-change by stage three never reaches the history
    generate
        for (genvar k = 0; k < PIN_BITS; k = k + 1) begin : g_settle
            logic level;
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    level <= PINS_IDLE[k];
                end else if (stage2_bits[k] == stage3_bits[k]) begin
                    level <= stage3_bits[k];
                end
            end
            assign settled_bits[k] = level;
        end
    endgenerate

    // the settled bit clock is the level before the fall being looked for
    assign clk_level = settled.bit_clk;

    // one strobe per accepted high-to-low change
    assign fall = clk_level & ~stage2.bit_clk & ~stage3.bit_clk; // R10

    // the stored bit is the output polarity: low means ramp up
    always_comb begin
        if (settled.encode_sel) begin
            sel_bit = ~settled.cmp_above; // R2 R6
        end else begin
            sel_bit = ~settled.data_in; // R7 R8 R12
        end
    end

    generate
        if (HIST_LEN > 1) begin : g_shift
            assign next_history = {history[HIST_LEN-2:0], sel_bit}; // R4 R5
        end else begin : g_single
            assign next_history = sel_bit;
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            history <= HIST_IDLE; // R14
        end else if (fall) begin
            history <= next_history; // R5
        end
    end

    // outputs are registered copies so the pins never glitch between edges
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_digital_out <= HIST_IDLE[0]; // R14
            o_ramp_up <= ~HIST_IDLE[0];
        end else if (fall) begin
            o_digital_out <= sel_bit; // R1
            o_ramp_up <= ~sel_bit; // R9 R13
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_coinc_n <= sdm_pkg::COINC_INACTIVE;
        end else if (fall) begin
            o_coinc_n <= ~(&next_history | ~|next_history); // R3
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bit_strobe <= 1'h0;
        end else begin
            o_bit_strobe <= fall;
        end
    end

    // checks below read the settled pins, the same values the history takes
    sequence s_fall_enc;
        fall && settled.encode_sel;
    endsequence

    sequence s_fall_dec;
        fall && !settled.encode_sel;
    endsequence

    sequence s_fall_uniform;
        fall && (&next_history || !(|next_history));
    endsequence

    a_out_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        !fall |=> $stable(o_digital_out))
        else $error("digital output changed without a bit clock fall");

    a_encode_sign: assert property (@(posedge i_clk) disable iff (i_rst) // R2
        s_fall_enc |=> o_digital_out == !$past(settled.cmp_above))
        else $error("encode output does not follow comparator sign");

    a_decode_invert: assert property (@(posedge i_clk) disable iff (i_rst) // R8
        s_fall_dec |=> o_digital_out == !$past(settled.data_in))
        else $error("decode output is not the inverted data input");

    a_coinc_match: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        o_coinc_n == !(&history || !(|history)))
        else $error("coincidence output disagrees with history");

    a_history_shift: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        fall |=> history[0] == o_digital_out && history[HIST_LEN-1] == $past(history[HIST_LEN-2]))
        else $error("history did not shift by one");

    a_ramp_dir: assert property (@(posedge i_clk) disable iff (i_rst) // R13
        o_ramp_up != o_digital_out)
        else $error("ramp direction not tied to sign bit");

    a_one_bit: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        fall |=> !fall ##0 o_bit_strobe ##1 !o_bit_strobe)
        else $error("more than one bit taken per clock fall");

    a_reset_idle: assert property (@(posedge i_clk) disable iff (i_rst) // R14
        $past(i_rst) |-> history == HIST_IDLE && o_coinc_n)
        else $error("history not idle after reset");

    a_loop_toggle: assert property (@(posedge i_clk) disable iff (i_rst) // R12
        s_fall_dec ##0 (settled.data_in == o_digital_out) |=> $changed(o_digital_out))
        else $error("looped decode did not toggle");

    a_ramp_encode: assert property (@(posedge i_clk) disable iff (i_rst) // R9
        s_fall_enc |=> o_ramp_up == $past(settled.cmp_above))
        else $error("encode ramp does not follow comparator");

    a_ramp_decode: assert property (@(posedge i_clk) disable iff (i_rst) // R9
        s_fall_dec |=> o_ramp_up == $past(settled.data_in))
        else $error("decode ramp does not follow data input");

    a_encode_loads: assert property (@(posedge i_clk) disable iff (i_rst) // R6
        s_fall_enc |=> history[0] == !$past(settled.cmp_above))
        else $error("encode did not load the comparison");

    a_decode_loads: assert property (@(posedge i_clk) disable iff (i_rst) // R7
        s_fall_dec |=> history[0] == !$past(settled.data_in))
        else $error("decode did not load the data input");

    a_hist_hold: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        !fall |=> $stable(history))
        else $error("history moved without a bit clock fall");

    a_coinc_active: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        s_fall_uniform |=> !o_coinc_n)
        else $error("coincidence not flagged on uniform history");

    a_coinc_clear: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        fall && !(&next_history || !(|next_history)) |=> o_coinc_n)
        else $error("coincidence flagged on mixed history");

    a_strobe_cause: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        o_bit_strobe |-> $past(fall))
        else $error("bit strobe without a bit clock fall");

    a_reset_outputs: assert property (@(posedge i_clk) disable iff (i_rst) // R14
        $past(i_rst) |-> !o_digital_out && o_ramp_up && !o_bit_strobe)
        else $error("outputs not idle after reset");
endmodule

// ==== sdm_far_end.sv ====
// far side model: bit clock source and serial channel with loopback
// assumes i_clk is the system clock; o_bit_clk moves 2 ns after its rise, o_data_in follows its inputs directly
`timescale 1ns/100ps
module sdm_far_end (
    input wire logic i_clk,
    input wire logic i_loop,
    input wire logic i_data,
    input wire logic i_digital_out,
    output logic o_bit_clk,
    output logic o_data_in
);
    logic [2:0] phase = 3'h0;
    always @(posedge i_clk) begin
        phase <= #2 phase + 3'h1;
    end
    // one bit per eight clocks, both phases long enough to be seen
    assign o_bit_clk = phase[2];
    assign o_data_in = i_loop ? i_digital_out : i_data;
endmodule

// ==== slope_delta_modulator_logic_tb.sv ====
// table-driven bench for the slope delta modulator core
// assumes sdm_core and the far side model are compiled first
`timescale 1ns/100ps
module slope_delta_modulator_logic_tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic sel = 1'h0;
    logic cmp = 1'h0;
    logic dat = 1'h0;
    logic loop = 1'h0;
    logic bclk, din, dout, ramp, coinc_n, strobe, last;
    logic dout3, ramp3, coinc3, strobe3;
    logic [6:0] row;
    // rows hold {select, comparator, data} then the expected
    // {output, ramp, coincidence of 4 stages, coincidence of 3 stages}
    logic [6:0] rows [10] = '{7'h0b, 7'h4b, 7'h0a, 7'h48, 7'h67,
        7'h17, 7'h66, 7'h74, 7'h2b, 7'h5b};
    int bad_count = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    sdm_far_end u_far (.i_clk(clk), .i_loop(loop), .i_data(dat), .i_digital_out(dout),
        .o_bit_clk(bclk), .o_data_in(din));
    sdm_core #(.HIST_LEN(4)) u_dut (.i_clk(clk), .i_rst(rst), .i_bit_clk(bclk),
        .i_cmp_above(cmp), .i_data_in(din), .i_encode_sel(sel), .o_digital_out(dout),
        .o_ramp_up(ramp), .o_coinc_n(coinc_n), .o_bit_strobe(strobe));
    sdm_core #(.HIST_LEN(3)) u_dut_short (.i_clk(clk), .i_rst(rst), .i_bit_clk(bclk),
        .i_cmp_above(cmp), .i_data_in(din), .i_encode_sel(sel), .o_digital_out(dout3),
        .o_ramp_up(ramp3), .o_coinc_n(coinc3), .o_bit_strobe(strobe3));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // output must hold between strobes; a missing strobe counts as a mismatch
    task automatic next_bit;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #2;
            n++;
            if (strobe !== 1'h1)
                check({2'h0, dout3, dout}, {2'h0, last, last});
        end while (strobe !== 1'h1 && n < 20);
        if (strobe !== 1'h1)
            bad_count++;
    endtask
    initial begin
        // the whole run needs about 130 clocks; this allows nearly four times that
        #20000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        #2 rst = 1'h0;
        check({dout, ramp, coinc_n, strobe}, 4'h6);
        check({dout3, ramp3, coinc3, strobe3}, 4'h6);
        last = 1'h0;
        foreach (rows[i]) begin
            row = rows[i];
            {sel, cmp, dat} = row[6:4];
            next_bit();
            check({dout, ramp, coinc_n, strobe}, {row[3:1], 1'h1});
            check({dout3, ramp3, coinc3, strobe3}, {row[3:2], row[0], 1'h1});
            last = dout;
        end
        $display("table done");
        sel = 1'h0;
        loop = 1'h1;
        repeat (4) begin
            next_bit();
            check({dout, ramp, coinc_n, coinc3}, {!last, last, 2'h3});
            last = dout;
        end
        $display("loopback done");
        rst = 1'h1;
        #2;
        check({dout, ramp, coinc_n, strobe}, 4'h6);
        check({dout3, ramp3, coinc3, strobe3}, 4'h6);
        @(posedge clk);
        #2 rst = 1'h0;
        last = 1'h0;
        loop = 1'h0;
        dat = 1'h1;
        next_bit();
        check({dout, ramp, coinc_n, strobe}, 4'h7);
        check({dout3, ramp3, coinc3, strobe3}, 4'h7);
        $display("reset done");
        summarize();
    end
endmodule
